// file: verilog/lin_frame_signal_packer.v
// Purpose: Builds outgoing LIN frame responses from signal values.
// Assumes: Descriptors outside answer lookups in-cycle; tables load by strobes.
// Notes: One signal slot per cycle, then one checksum byte per cycle.
`timescale 1ns/1ps
`default_nettype none
`include "lin_frame_regs.vh"

module lin_frame_signal_packer #(
	parameter FRAMES = `FRAME_COUNT, // Unconditional frame slots
	parameter SLOTS = `SIGNAL_SLOTS // Signal entries per frame
) (
	input wire sys_clk, // System clock, 40 MHz
	input wire rst, // Asynchronous reset, active high
	input wire [1:0] nodeType, // Off, master or slave
	input wire frameCfgWe, // Write frame header fields
	input wire [4:0] cfgFrame, // Frame number 1..25
	input wire [1:0] cfgKind, // Frame direction
	input wire [5:0] cfgId, // Frame identifier
	input wire [3:0] cfgSize, // Data length in bytes
	input wire cfgChecksumType, // 0 classic, 1 enhanced
	input wire cfgEventFlag, // Takes part in event-triggered frame
	input wire slotCfgWe, // Write one signal entry
	input wire [3:0] cfgSlot, // Entry 0..14 of cfgFrame
	input wire [7:0] cfgSignalNum, // Descriptor number, 0 empty
	input wire [5:0] cfgBitOffset, // Bit offset in data field
	input wire [1:0] etKind, // Event-triggered frame direction
	input wire [5:0] etId, // Event-triggered identifier
	input wire [3:0] etSize, // Event-triggered data length
	input wire etChecksumType, // Event-triggered checksum type
	input wire etCollisionTable, // Event frame has a collision table
	input wire [24:0] etFrameList, // Five 5-bit frame numbers, #1 low
	input wire buildStart, // Pulse: build a response
	input wire [4:0] buildSel, // 1..25 frame, 0 event-triggered
	output wire [7:0] signalNum, // Descriptor being looked up
	input wire [2:0] signalEncoding, // Looked-up encoding
	input wire [6:0] signalSize, // Looked-up size in bits, 1..64
	input wire [31:0] signalValue, // Looked-up input value
	input wire signalDefined, // Looked-up value is defined
	input wire [63:0] signalInit, // Looked-up initial value
	input wire [27:0] code_lower_limit, // Looked-up lower limit
	input wire [27:0] code_upper_limit, // Looked-up upper limit
	input wire [15:0] signalGain, // Looked-up gain
	input wire [31:0] signalOffset, // Looked-up offset
	input wire respErrEvent, // Pulse: response error seen
	input wire respStatusTaken, // Pulse: status reported on the bus
	output wire busy, // Build in progress
	output reg frameDone, // Pulse: result registers valid
	output reg framePublish_ff, // Built frame is to be transmitted
	output reg [63:0] frameData_ff, // Data field, byte 0 in bits 7:0
	output reg [3:0] frameLen_ff, // Data length in bytes
	output reg [7:0] framePid_ff, // Protected identifier
	output reg [7:0] frameChecksum_ff, // Checksum byte
	output reg [3:0] skippedCount_ff, // Logical signals dropped
	output reg collisionValid_ff, // Event frame names a collision table
	output reg respStatus_ff, // Slave response status bit
	output reg respStatusDefined_ff // Status output is meaningful
);
	// ----------------------------------------------------------------
	// States
	// ----------------------------------------------------------------
	localparam IDLE = 2'h0;
	localparam WALK = 2'h1;
	localparam SUM = 2'h2;
	localparam DONE = 2'h3;

	// ----------------------------------------------------------------
	// Frame table, flip-flops indexed by frame number minus one
	// ----------------------------------------------------------------
	reg [1:0] kindMem_ff [0:FRAMES-1]; // Direction per frame
	reg [5:0] idMem_ff [0:FRAMES-1]; // Identifier per frame
	reg [3:0] sizeMem_ff [0:FRAMES-1]; // Length per frame
	reg csMem_ff [0:FRAMES-1]; // Checksum type per frame
	reg evtMem_ff [0:FRAMES-1]; // Event-triggered flag per frame
	reg [7:0] numMem_ff [0:FRAMES*SLOTS-1]; // Descriptor per entry
	reg [5:0] offMem_ff [0:FRAMES*SLOTS-1]; // Bit offset per entry

	reg [1:0] state_ff; // Builder state
	reg [4:0] curFrame_ff; // Frame index 0..24 being built
	reg [3:0] slot_ff; // Entry being walked
	reg [2:0] byteIdx_ff; // Byte being summed
	reg [63:0] work_ff; // Data field under construction
	reg [3:0] len_ff; // Length for this build
	reg cs_ff; // Checksum type for this build
	reg [5:0] id_ff; // Identifier for this build
	reg publish_ff; // Direction is publish and node active
	reg [3:0] skip_ff; // Running dropped count
	integer i;

	// Write index into the frame table
	wire [4:0] cfgIdx = cfgFrame - 5'h01;
	wire cfgFrameOk = (cfgFrame != 5'h00) && (cfgFrame <= FRAMES);
	wire [31:0] cfgEntryWide = cfgIdx * SLOTS + cfgSlot; // Integer-wide table index
	wire [8:0] cfgEntry = cfgEntryWide[8:0]; // Table stays under 512 entries
	wire [31:0] walkEntryWide = curFrame_ff * SLOTS + slot_ff; // Integer-wide walk index
	wire [8:0] walkEntry = walkEntryWide[8:0]; // Table stays under 512 entries

	// ----------------------------------------------------------------
	// Configuration writes
	// ----------------------------------------------------------------
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < FRAMES; i = i + 1) begin
				kindMem_ff[i] <= `KIND_UNDEF;
				idMem_ff[i] <= 6'h00;
				sizeMem_ff[i] <= `RESET_SIZE;
				csMem_ff[i] <= `CS_CLASSIC;
				evtMem_ff[i] <= 1'b0;
			end
			for (i = 0; i < FRAMES * SLOTS; i = i + 1) begin
				numMem_ff[i] <= 8'h00;
				offMem_ff[i] <= 6'h00;
			end
		end else begin
			// Out-of-range frame numbers are dropped, not aliased
			if (frameCfgWe && cfgFrameOk) begin
				kindMem_ff[cfgIdx] <= cfgKind;
				idMem_ff[cfgIdx] <= cfgId & `ID_MAX;
				// Lengths outside 1..8 are pinned to the nearest end
				if (cfgSize == 4'h0) begin
					sizeMem_ff[cfgIdx] <= `RESET_SIZE;
				end else if (cfgSize > `MAX_SIZE) begin
					sizeMem_ff[cfgIdx] <= `MAX_SIZE;
				end else begin
					sizeMem_ff[cfgIdx] <= cfgSize;
				end
				csMem_ff[cfgIdx] <= cfgChecksumType;
				evtMem_ff[cfgIdx] <= cfgEventFlag;
			end
			if (slotCfgWe && cfgFrameOk && cfgSlot < SLOTS) begin
				numMem_ff[cfgEntry] <= cfgSignalNum;
				offMem_ff[cfgEntry] <= cfgBitOffset;
			end
		end
	end

	// ----------------------------------------------------------------
	// Event-triggered source: highest-priority usable grouped frame
	// ----------------------------------------------------------------
	reg [4:0] etSrc; // Chosen frame index
	reg etFound; // A grouped frame is usable
	reg [4:0] etNum; // Scratch frame number
	integer k;
	always @* begin
		etSrc = 5'h00;
		etFound = 1'b0;
		etNum = 5'h00;
		// Walk from #5 down so #1 is left winning
		for (k = `ET_GROUP - 1; k >= 0; k = k - 1) begin
			etNum = etFrameList[k*5 +: 5];
			// Number zero is no entry; flag must be set
			if (etNum != 5'h00 && etNum <= FRAMES) begin
				if (evtMem_ff[etNum - 5'h01]) begin
					etSrc = etNum - 5'h01;
					etFound = 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Signal lookup and conversion for the entry being walked
	// ----------------------------------------------------------------
	wire [7:0] curNum = numMem_ff[walkEntry];
	wire [5:0] curOff = offMem_ff[walkEntry];
	wire entryUsed = (curNum != 8'h00) && (curNum <= `SIGNAL_DESCS);
	wire [63:0] code;
	wire codeSend;
	assign signalNum = (state_ff == WALK) ? curNum : 8'h00;

	lin_signal_encoder encoder (
		.encoding(signalEncoding),
		.value(signalValue),
		.valueDefined(signalDefined),
		.initValue(signalInit),
		.codeLowerLimit(code_lower_limit),
		.codeUpperLimit(code_upper_limit),
		.gain(signalGain),
		.valueOffset(signalOffset),
		.code(code),
		.send(codeSend)
	);

	// Field mask; sizes of 64 or more fill the whole data field
	wire [63:0] sizeMask = (signalSize >= `FULL_WIDTH) ? {64{1'b1}} :
		((64'h1 << signalSize) - 64'h1);
	wire [63:0] placeMask = sizeMask << curOff;
	wire [63:0] placeBits = (code & sizeMask) << curOff;
	wire [63:0] nxt_work = (work_ff & ~placeMask) | placeBits;

	// ----------------------------------------------------------------
	// Protected identifier and checksum
	// ----------------------------------------------------------------
	wire parity0 = id_ff[0] ^ id_ff[1] ^ id_ff[2] ^ id_ff[4];
	wire parity1 = ~(id_ff[1] ^ id_ff[3] ^ id_ff[4] ^ id_ff[5]);
	wire [7:0] pid = {parity1, parity0, id_ff};
	wire [7:0] checksum;
	wire sumClear = (state_ff == WALK) && (slot_ff == SLOTS - 1);
	wire sumAdd = (state_ff == SUM);

	lin_checksum summer (
		.sys_clk(sys_clk),
		.rst(rst),
		.clear(sumClear),
		.seed(cs_ff ? pid : 8'h00),
		.addEn(sumAdd),
		.addByte(work_ff[byteIdx_ff*8 +: 8]),
		.checksum(checksum)
	);

	// Node off refuses every build
	wire nodeOn = (nodeType == `NODE_MASTER) || (nodeType == `NODE_SLAVE);
	wire selOk = (buildSel <= FRAMES) && ((buildSel != 5'h00) || etFound);
	wire [4:0] selIdx = (buildSel == 5'h00) ? etSrc : (buildSel - 5'h01);
	wire [3:0] etLen = (etSize == 4'h0) ? `RESET_SIZE : (etSize > `MAX_SIZE) ? `MAX_SIZE : etSize;
	assign busy = (state_ff != IDLE);

	// ----------------------------------------------------------------
	// Builder state machine
	// ----------------------------------------------------------------
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff <= IDLE;
			curFrame_ff <= 5'h00;
			slot_ff <= 4'h0;
			byteIdx_ff <= 3'h0;
			work_ff <= 64'h0;
			len_ff <= `RESET_SIZE;
			cs_ff <= `CS_CLASSIC;
			id_ff <= 6'h00;
			publish_ff <= 1'b0;
			skip_ff <= 4'h0;
		end else begin
			case (state_ff)
				IDLE: begin
					if (buildStart && nodeOn && selOk) begin
						state_ff <= WALK;
						curFrame_ff <= selIdx;
						slot_ff <= 4'h0;
						work_ff <= 64'h0;
						skip_ff <= 4'h0;
						// Event frame uses its own header fields
						if (buildSel == 5'h00) begin
							id_ff <= etId;
							len_ff <= etLen;
							cs_ff <= etChecksumType;
							publish_ff <= (etKind == `KIND_PUBLISH);
						end else begin
							id_ff <= idMem_ff[selIdx];
							len_ff <= sizeMem_ff[selIdx];
							cs_ff <= csMem_ff[selIdx];
							publish_ff <= (kindMem_ff[selIdx] == `KIND_PUBLISH);
						end
					end
				end
				WALK: begin
					// Empty entries keep their offset out of play
					if (entryUsed) begin
						if (codeSend) begin
							work_ff <= nxt_work;
						end else begin
							skip_ff <= skip_ff + 4'h1;
						end
					end
					if (slot_ff == SLOTS - 1) begin
						state_ff <= SUM;
						byteIdx_ff <= 3'h0;
					end else begin
						slot_ff <= slot_ff + 4'h1;
					end
				end
				SUM: begin
					// One byte per cycle up to the frame length
					if ({1'b0, byteIdx_ff} == len_ff - 4'h1) begin
						state_ff <= DONE;
					end else begin
						byteIdx_ff <= byteIdx_ff + 3'h1;
					end
				end
				DONE: begin
					state_ff <= IDLE;
				end
				default: begin
					state_ff <= IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Result registers, loaded as the build completes
	// ----------------------------------------------------------------
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			frameDone <= 1'b0;
			framePublish_ff <= 1'b0;
			frameData_ff <= 64'h0;
			frameLen_ff <= `RESET_SIZE;
			framePid_ff <= 8'h00;
			frameChecksum_ff <= 8'h00;
			skippedCount_ff <= 4'h0;
			collisionValid_ff <= 1'b0;
		end else begin
			frameDone <= (state_ff == DONE);
			if (state_ff == DONE) begin
				// Subscribe or undefined frames report no transmit
				framePublish_ff <= publish_ff;
				frameData_ff <= work_ff;
				frameLen_ff <= len_ff;
				framePid_ff <= pid;
				frameChecksum_ff <= checksum;
				skippedCount_ff <= skip_ff;
				collisionValid_ff <= etCollisionTable;
			end
		end
	end

	// ----------------------------------------------------------------
	// Slave response status; frozen while master or off
	// ----------------------------------------------------------------
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			respStatus_ff <= 1'b0;
			respStatusDefined_ff <= 1'b0;
		end else begin
			respStatusDefined_ff <= (nodeType == `NODE_SLAVE);
			if (nodeType == `NODE_SLAVE) begin
				// A new error in the reporting cycle is not lost
				if (respErrEvent) begin
					respStatus_ff <= 1'b1;
				end else if (respStatusTaken) begin
					respStatus_ff <= 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: common/lin_frame_regs.vh
// Purpose: Constants shared by the LIN frame packer design files.
// Assumes: Included by bare name; definitions only.
// Notes: Encodings of kinds, node types, signal encodings and limits.
`ifndef LIN_FRAME_REGS_VH
`define LIN_FRAME_REGS_VH

// ----------------------------------------------------------------
// Frame kind and node type codes
// ----------------------------------------------------------------
`define KIND_UNDEF 2'h0
`define KIND_PUBLISH 2'h1
`define KIND_SUBSCRIBE 2'h2
`define NODE_OFF 2'h0
`define NODE_MASTER 2'h1
`define NODE_SLAVE 2'h2

// ----------------------------------------------------------------
// Signal encoding codes
// ----------------------------------------------------------------
`define ENC_UNDEF 3'h0
`define ENC_LOGICAL 3'h1
`define ENC_PHYSICAL 3'h2
`define ENC_BCD 3'h3
`define ENC_ASCII 3'h4

// ----------------------------------------------------------------
// Table sizes and field limits
// ----------------------------------------------------------------
`define FRAME_COUNT 25
`define SIGNAL_SLOTS 15
`define SIGNAL_DESCS 8'h82
`define ET_GROUP 5
`define ID_MAX 6'h3F
`define ASCII_MASK 64'h00000000000000FF
`define GAIN_FRAC 8
`define CS_CLASSIC 1'b0
`define RESET_SIZE 4'h1
`define MAX_SIZE 4'h8
`define FULL_WIDTH 7'h40

`endif

// file: verilog/lin_signal_encoder.v
// Purpose: Turns one outgoing signal value into its LIN signal code.
// Assumes: Purely combinational; descriptor fields are stable inputs.
// Notes: Physical scale is given as a fixed-point gain (reciprocal).
`timescale 1ns/1ps
`default_nettype none
`include "lin_frame_regs.vh"

module lin_signal_encoder (
	input wire [2:0] encoding, // Signal encoding code
	input wire [31:0] value, // Input value, signed for physical
	input wire valueDefined, // Input value is valid
	input wire [63:0] initValue, // Initial value for undefined input
	input wire [27:0] codeLowerLimit, // Lower code limit
	input wire [27:0] codeUpperLimit, // Upper code limit
	input wire [15:0] gain, // Code units per value unit, 8 fraction bits
	input wire [31:0] valueOffset, // Offset subtracted before gain
	output reg [63:0] code, // Signal code to pack
	output reg send // Code is to be written into frame
);
	// ----------------------------------------------------------------
	// Physical conversion, kept signed to avoid wrap on negatives
	// ----------------------------------------------------------------
	wire signed [32:0] diff = $signed({value[31], value}) - $signed({valueOffset[31], valueOffset});
	wire signed [49:0] prod = diff * $signed({1'b0, gain});
	wire signed [49:0] scaled = prod >>> `GAIN_FRAC;
	wire signed [49:0] lowS = $signed({22'h000000, codeLowerLimit});
	wire signed [49:0] highS = $signed({22'h000000, codeUpperLimit});
	wire [27:0] logicalVal = value[27:0];
	wire logicalIn = (value[31:28] == 4'h0) && (logicalVal >= codeLowerLimit) &&
		(logicalVal <= codeUpperLimit);

	// Selection by encoding; undefined input always falls back to init
	always @* begin
		code = 64'h0;
		send = 1'b1;
		if (!valueDefined || encoding == `ENC_UNDEF) begin
			code = initValue;
		end else begin
			case (encoding)
				`ENC_LOGICAL: begin
					code = {32'h0, value};
					send = logicalIn;
				end
				`ENC_BCD: begin
					code = {32'h0, value};
				end
				`ENC_ASCII: begin
					code = {32'h0, value} & `ASCII_MASK;
				end
				`ENC_PHYSICAL: begin
					// Saturate instead of wrapping when out of range
					if (scaled < lowS) begin
						code = {36'h0, codeLowerLimit};
					end else if (scaled > highS) begin
						code = {36'h0, codeUpperLimit};
					end else begin
						code = {36'h0, scaled[27:0]};
					end
				end
				default: begin
					code = initValue;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: verilog/lin_checksum.v
// Purpose: Accumulates the LIN checksum one byte per cycle.
// Assumes: Same clock as the frame builder.
// Notes: Carry folds back on every add; the output is the inverted sum.
`timescale 1ns/1ps
`default_nettype none

module lin_checksum (
	input wire sys_clk, // System clock
	input wire rst, // Asynchronous reset, active high
	input wire clear, // Load the seed
	input wire [7:0] seed, // Zero for classic, protected id for enhanced
	input wire addEn, // Add one byte this cycle
	input wire [7:0] addByte, // Byte to add
	output wire [7:0] checksum // Inverted running sum
);
	reg [7:0] sum_ff; // Running sum
	wire [8:0] raw = {1'b0, sum_ff} + {1'b0, addByte};
	wire [7:0] nxt_wrap = raw[7:0] + {7'h00, raw[8]};

	// ----------------------------------------------------------------
	// Accumulator
	// ----------------------------------------------------------------
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sum_ff <= 8'h00;
		end else if (clear) begin
			sum_ff <= seed;
		end else if (addEn) begin
			sum_ff <= nxt_wrap;
		end
	end

	assign checksum = ~sum_ff;
endmodule
`default_nettype wire

// file: verification/lin_frame_checker.sv
// Purpose: Port-level temporal checks for the frame packer.
// Assumes: Single clock domain, rst async active high.
// Notes: Sees only top-level ports; attached by bind below.
`timescale 1ns/1ps
`default_nettype none
module lin_frame_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] nodeType,
	input wire logic buildStart,
	input wire logic [4:0] buildSel,
	input wire logic respErrEvent,
	input wire logic respStatusTaken,
	input wire logic busy,
	input wire logic frameDone,
	input wire logic [3:0] frameLen_ff,
	input wire logic [63:0] frameData_ff,
	input wire logic [7:0] frameChecksum_ff,
	input wire logic [7:0] signalNum,
	input wire logic respStatus_ff,
	input wire logic respStatusDefined_ff
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	len_in_range_a: assert property (frameDone |-> frameLen_ff >= 4'h1 && frameLen_ff <= 4'h8)
		else $error("frame length out of range");
	done_ends_busy_a: assert property (frameDone |-> !busy && $past(busy))
		else $error("done without a build");
	// Off node must not accept a build
	off_no_build_a: assert property (buildStart && !busy && nodeType != 2'h1 && nodeType != 2'h2 |=> !busy)
		else $error("build taken while node off");
	start_takes_a: assert property (buildStart && !busy && nodeType == 2'h1 && buildSel >= 5'h01 && buildSel <= 5'h19 |=> busy)
		else $error("valid build not taken");
	master_undef_a: assert property (nodeType == 2'h1 && $past(nodeType) == 2'h1 |-> !respStatusDefined_ff)
		else $error("status defined in master mode");
	master_frozen_a: assert property (nodeType == 2'h1 |=> $stable(respStatus_ff))
		else $error("status moved in master mode");
	slave_err_set_a: assert property (nodeType == 2'h2 && respErrEvent |=> respStatus_ff)
		else $error("status not set on error");
	slave_clear_a: assert property (nodeType == 2'h2 && respStatusTaken && !respErrEvent |=> !respStatus_ff)
		else $error("status not cleared");
	// Lookup number is zero outside a build
	idle_lookup_a: assert property (!busy |-> signalNum == 8'h00)
		else $error("lookup while idle");
	results_hold_a: assert property (!frameDone |-> $stable(frameData_ff) && $stable(frameChecksum_ff))
		else $error("results changed without done");
endmodule
bind lin_frame_signal_packer lin_frame_checker lin_frame_checker_i (.sys_clk, .rst, .nodeType,
	.buildStart, .buildSel, .respErrEvent, .respStatusTaken, .busy, .frameDone, .frameLen_ff,
	.frameData_ff, .frameChecksum_ff, .signalNum, .respStatus_ff, .respStatusDefined_ff);
`default_nettype wire

// file: verification/lin_signal_source.sv
// Purpose: Descriptor store answering the packer's lookups.
// Assumes: Same-cycle combinational answer to signalNum.
// Notes: Unused numbers answer an undefined, odd pattern.
`timescale 1ns/1ps
`default_nettype none
`include "lin_frame_regs.vh"
module lin_signal_source (
	input wire logic [7:0] signalNum,
	output logic [2:0] signalEncoding,
	output logic [6:0] signalSize,
	output logic [31:0] signalValue,
	output logic signalDefined,
	output logic [63:0] signalInit,
	output logic [27:0] code_lower_limit,
	output logic [27:0] code_upper_limit,
	output logic [15:0] signalGain,
	output logic [31:0] signalOffset
);
	// ------------------------------------------------------------
	// Descriptor table, numbers 1..8 in use
	// ------------------------------------------------------------
	always_comb begin
		signalEncoding = `ENC_BCD;
		signalSize = 7'h08;
		signalValue = 32'h0;
		signalDefined = 1'b1;
		signalInit = 64'h0;
		code_lower_limit = 28'h3;
		code_upper_limit = 28'h96;
		signalGain = 16'h0100;
		signalOffset = 32'h64;
		case (signalNum)
			8'h01: begin // Logical at upper limit
				signalEncoding = `ENC_LOGICAL;
				signalValue = 32'h9;
				code_lower_limit = 28'h2;
				code_upper_limit = 28'h9;
			end
			8'h02: begin // Logical one above limit
				signalEncoding = `ENC_LOGICAL;
				signalValue = 32'hA;
				code_lower_limit = 28'h2;
				code_upper_limit = 28'h9;
			end
			8'h03: begin
				signalSize = 7'h10;
				signalValue = 32'h1234;
			end
			8'h04: begin // High byte must be masked off
				signalEncoding = `ENC_ASCII;
				signalSize = 7'h10;
				signalValue = 32'hABCD;
			end
			8'h05: begin // Clamps high
				signalEncoding = `ENC_PHYSICAL;
				signalValue = 32'h12C;
			end
			8'h06: begin
				signalDefined = 1'b0;
				signalInit = 64'h5A;
			end
			8'h07: begin // Within limits, gain two
				signalEncoding = `ENC_PHYSICAL;
				signalValue = 32'h78;
				signalGain = 16'h0200;
			end
			8'h08: begin // Negative code clamps low
				signalEncoding = `ENC_PHYSICAL;
				signalValue = 32'h32;
			end
			default: begin
				signalEncoding = `ENC_UNDEF;
				signalDefined = 1'b0;
				signalValue = 32'hA5A5A5A5;
				signalInit = 64'hC3C3C3C3C3C3C3C3;
			end
		endcase
	end
endmodule
`default_nettype wire

// file: verification/tb_lin_frame_signal_packer.sv
// Purpose: Self-checking bench for the frame packer.
// Assumes: Inputs change on the falling edge only.
// Notes: Expected bytes are worked out by hand from the descriptors.
`timescale 1ns/1ps
`default_nettype none
`include "lin_frame_regs.vh"
module tb_lin_frame_signal_packer;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] nodeType = 2'h0, cfgKind = 2'h0, etKind = 2'h0;
	logic frameCfgWe = 1'b0, slotCfgWe = 1'b0, cfgChecksumType = 1'b0, cfgEventFlag = 1'b0;
	logic etChecksumType = 1'b0, etCollisionTable = 1'b0, buildStart = 1'b0;
	logic respErrEvent = 1'b0, respStatusTaken = 1'b0;
	logic [4:0] cfgFrame = 5'h0, buildSel = 5'h0;
	logic [5:0] cfgId = 6'h0, cfgBitOffset = 6'h0, etId = 6'h0;
	logic [3:0] cfgSize = 4'h0, cfgSlot = 4'h0, etSize = 4'h0;
	logic [7:0] cfgSignalNum = 8'h0, signalNum, framePid_ff, frameChecksum_ff;
	logic [24:0] etFrameList = 25'h0;
	logic [2:0] signalEncoding;
	logic [6:0] signalSize;
	logic [31:0] signalValue, signalOffset;
	logic [63:0] signalInit, frameData_ff, d;
	logic [27:0] code_lower_limit, code_upper_limit;
	logic [15:0] signalGain;
	logic signalDefined, busy, frameDone, framePublish_ff, collisionValid_ff;
	logic respStatus_ff, respStatusDefined_ff;
	logic [3:0] frameLen_ff, skippedCount_ff;
	integer fails = 0, n_compared = 0, cycles = 0;
	lin_frame_signal_packer lin_frame_signal_packer_i (.sys_clk, .rst, .nodeType, .frameCfgWe,
		.cfgFrame, .cfgKind, .cfgId, .cfgSize, .cfgChecksumType, .cfgEventFlag, .slotCfgWe, .cfgSlot,
		.cfgSignalNum, .cfgBitOffset, .etKind, .etId, .etSize, .etChecksumType, .etCollisionTable,
		.etFrameList, .buildStart, .buildSel, .signalNum, .signalEncoding, .signalSize, .signalValue,
		.signalDefined, .signalInit, .code_lower_limit, .code_upper_limit, .signalGain, .signalOffset,
		.respErrEvent, .respStatusTaken, .busy, .frameDone, .framePublish_ff, .frameData_ff,
		.frameLen_ff, .framePid_ff, .frameChecksum_ff, .skippedCount_ff, .collisionValid_ff,
		.respStatus_ff, .respStatusDefined_ff);
	lin_signal_source lin_signal_source_i (.signalNum, .signalEncoding, .signalSize, .signalValue,
		.signalDefined, .signalInit, .code_lower_limit, .code_upper_limit, .signalGain, .signalOffset);
	// ------------------------------------------------------------
	// Clock, watchdog and helpers
	// ------------------------------------------------------------
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin // A hang ends the run as a failure
		cycles = cycles + 1;
		if (cycles == 3000) begin
			fails = fails + 1;
			wrap_up;
		end
	end
	task wrap_up;
		begin
			$display("compared %0d mismatches %0d", n_compared, fails);
			if (fails == 0 && n_compared > 0) $display("bench passed");
			else $display("bench failed");
			$finish;
		end
	endtask
	task chk(input [63:0] seen, input [63:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
			end
		end
	endtask
	// Inverted sum with carry folded back after every byte
	function automatic [7:0] csum(input [7:0] seed, input [63:0] v, input [3:0] n);
		reg [8:0] s;
		integer i;
		begin
			s = {1'b0, seed};
			for (i = 0; i < n; i = i + 1) begin
				s = s + v[8*i +: 8];
				s = {1'b0, s[7:0]} + s[8];
			end
			csum = ~s[7:0];
		end
	endfunction
	function automatic [7:0] pid(input [5:0] i);
		pid = {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
	endfunction
	task fcfg(input [4:0] f, input [1:0] k, input [5:0] id, input [3:0] sz, input cs, input fl);
		begin
			@(negedge sys_clk);
			{frameCfgWe, cfgFrame, cfgKind, cfgId, cfgSize} = {1'b1, f, k, id, sz};
			{cfgChecksumType, cfgEventFlag} = {cs, fl};
			@(negedge sys_clk);
			frameCfgWe = 1'b0;
		end
	endtask
	task scfg(input [4:0] f, input [3:0] sl, input [7:0] num, input [5:0] off);
		begin
			@(negedge sys_clk);
			{slotCfgWe, cfgFrame, cfgSlot, cfgSignalNum, cfgBitOffset} = {1'b1, f, sl, num, off};
			@(negedge sys_clk);
			slotCfgWe = 1'b0;
		end
	endtask
	task build(input [4:0] s, input [3:0] len);
		integer n;
		begin
			@(negedge sys_clk);
			{buildStart, buildSel} = {1'b1, s};
			@(negedge sys_clk);
			buildStart = 1'b0;
			n = 1;
			while (frameDone !== 1'b1 && n < 60) begin
				@(negedge sys_clk);
				n = n + 1;
			end
			chk(n, (len == 4'h0) ? 60 : 17 + len);
		end
	endtask
	task res(input p, input [63:0] v, input [3:0] l, input [7:0] id, input [7:0] cs, input [3:0] sk);
		begin
			chk(framePublish_ff, p);
			chk(frameData_ff, v);
			chk(frameLen_ff, l);
			chk(framePid_ff, id);
			chk(frameChecksum_ff, cs);
			chk(skippedCount_ff, sk);
		end
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
		@(negedge sys_clk);
		chk(frameLen_ff, 4'h1);
		nodeType = `NODE_MASTER;
		build(5'h03, 4'h1);
		res(1'b0, 64'h0, 4'h1, pid(6'h00), 8'hFF, 4'h0);
		fcfg(5'h01, `KIND_PUBLISH, 6'h10, 4'h8, 1'b0, 1'b0);
		scfg(5'h01, 4'h0, 8'h01, 6'h00);
		scfg(5'h01, 4'h1, 8'h02, 6'h08);
		scfg(5'h01, 4'h2, 8'h03, 6'h10);
		scfg(5'h01, 4'h3, 8'h04, 6'h20);
		scfg(5'h01, 4'h4, 8'h05, 6'h30);
		scfg(5'h01, 4'h5, 8'h06, 6'h38);
		scfg(5'h01, 4'h6, 8'h00, 6'h07);
		build(5'h01, 4'h8);
		d = 64'h5A96_00CD_1234_0009;
		res(1'b1, d, 4'h8, pid(6'h10), csum(8'h00, d, 4'h8), 4'h1);
		fcfg(5'h02, `KIND_SUBSCRIBE, 6'h3F, 4'h3, 1'b1, 1'b1);
		scfg(5'h02, 4'h0, 8'h07, 6'h00);
		scfg(5'h02, 4'h1, 8'h08, 6'h3C);
		build(5'h02, 4'h3);
		d = 64'h3000_0000_0000_0028;
		res(1'b0, d, 4'h3, pid(6'h3F), csum(pid(6'h3F), d, 4'h3), 4'h0);
		// Empty, out of range and unflagged entries come before frame 2
		{etKind, etId, etSize, etChecksumType} = {`KIND_PUBLISH, 6'h05, 4'h3, 1'b1};
		etCollisionTable = 1'b1;
		etFrameList = {5'h00, 5'h02, 5'h01, 5'h1B, 5'h00};
		build(5'h00, 4'h3);
		res(1'b1, d, 4'h3, pid(6'h05), csum(pid(6'h05), d, 4'h3), 4'h0);
		chk(collisionValid_ff, 1'b1);
		nodeType = `NODE_OFF;
		build(5'h01, 4'h0);
		chk(busy, 1'b0);
		nodeType = `NODE_SLAVE;
		@(negedge sys_clk);
		respErrEvent = 1'b1;
		@(negedge sys_clk);
		respErrEvent = 1'b0;
		chk({respStatusDefined_ff, respStatus_ff}, 2'h3);
		respStatusTaken = 1'b1;
		@(negedge sys_clk);
		respStatusTaken = 1'b0;
		chk(respStatus_ff, 1'b0);
		respErrEvent = 1'b1;
		@(negedge sys_clk);
		{respErrEvent, nodeType} = {1'b0, `NODE_MASTER};
		repeat (2) @(negedge sys_clk);
		respStatusTaken = 1'b1;
		@(negedge sys_clk);
		respStatusTaken = 1'b0;
		chk({respStatusDefined_ff, respStatus_ff}, 2'h1);
		wrap_up;
	end
endmodule
`default_nettype wire
